//--- fcp_pkg.sv
// fcp_pkg.sv: constants and register map of the counter/probe mode block,
// and the small pin synchroniser that the top module uses.
// assumes one 250 MHz clock CLK and a synchronous active-low reset RST_N.
package fcp_pkg;
    // ------------------------------------------------------------------
    // register map (Avalon-MM byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam logic [3:0] FCP_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FCP_ADDR_STATUS = 4'h4;
    localparam logic [3:0] FCP_ADDR_READING = 4'h8;
    localparam int FCP_ADDR_W = 4;
    // control fields and their values after reset
    localparam int FCP_CTRL_RUN_BIT = 0;
    localparam int FCP_CTRL_FREEZE_BIT = 1;
    localparam logic FCP_CTRL_RUN_RST = 1'b1;
    localparam logic FCP_CTRL_FREEZE_RST = 1'b0;
    // ------------------------------------------------------------------
    // counter and range constants
    // ------------------------------------------------------------------
    localparam int FCP_CNT_W = 23;
    localparam int FCP_VAL_W = 12;
    localparam int FCP_DIV_W = 16;
    localparam logic [FCP_VAL_W-1:0] FCP_FULL_SCALE = 12'hF9F;
    localparam logic [FCP_CNT_W-1:0] FCP_LIM_R0 = 23'h000FA0;
    localparam logic [FCP_CNT_W-1:0] FCP_LIM_R1 = 23'h009C40;
    localparam logic [FCP_CNT_W-1:0] FCP_LIM_R2 = 23'h061A80;
    localparam logic [FCP_CNT_W-1:0] FCP_LIM_R3 = 23'h3D0900;
    localparam int FCP_GATE_PERIODS = 40000;
    localparam int FCP_OSC_DIV = 6250;
    // converter signal-integrate length in counts
    localparam logic [11:0] FCP_INTEG_NORMAL = 12'h7D0;
    localparam logic [11:0] FCP_INTEG_SHORT = 12'h0C8;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        FCP_RNG_KHZ4 = 2'b00,
        FCP_RNG_KHZ40 = 2'b01,
        FCP_RNG_KHZ400 = 2'b10,
        FCP_RNG_MHZ4 = 2'b11
    } fcp_range_e;
    typedef enum logic [1:0]
    {
        FCP_MODE_CONV = 2'b00,
        FCP_MODE_COUNT = 2'b01,
        FCP_MODE_PROBE = 2'b10
    } fcp_mode_e;
endpackage

`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pins; only stage two is visible
module fcp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] PIN_IN,
    output logic [WIDTH-1:0] PIN_OUT
);
    typedef struct packed
    {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } fcp_sync_s;
    fcp_sync_s st_reg;
    fcp_sync_s st_next;

    always_comb
    begin
        st_next.stage1 = PIN_IN;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign PIN_OUT = st_reg.stage2;
endmodule // fcp_sync

//--- fcp_top.sv
// fcp_top.sv: mode selection, auto-ranging pulse counter and logic probe
// control, with an Avalon-MM register slave.
// assumes mode and probe pins are asynchronous static levels; the
// oscillator is a divided enable of CLK.
`timescale 1ns/1ps
module fcp_top
    import fcp_pkg::*;
#(
    parameter int GATE_PERIODS = fcp_pkg::FCP_GATE_PERIODS,
    parameter int OSC_DIV = fcp_pkg::FCP_OSC_DIV
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // avalon-mm slave
    input wire logic [fcp_pkg::FCP_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // mode pins
    input wire logic MEASUREMENT_SELECT,
    input wire logic RANGE_OR_COUNT_INPUT,
    input wire logic PROBE_SELECT,
    input wire logic POINT0_OR_LOW_PROBE_INPUT,
    input wire logic POINT1_OR_HIGH_PROBE_INPUT,
    input wire logic PEAK_READING_HOLD,
    // display and annunciators
    output logic [fcp_pkg::FCP_VAL_W-1:0] DISPLAY_VALUE,
    output logic OVERLOAD_TEXT,
    output logic THIRD_DECIMAL_POINT,
    output logic SECOND_DECIMAL_POINT,
    output logic FIRST_DECIMAL_POINT,
    output logic LAMP_HIGH,
    output logic LAMP_LOW,
    output logic BUZZER_ON,
    // converter control
    output logic CONV_HOLD_AUTOZERO,
    output logic [11:0] CONV_INTEG_COUNTS
);
    import fcp_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [FCP_DIV_W-1:0] osc_cnt;
        logic [FCP_DIV_W-1:0] gate_cnt;
        logic [FCP_CNT_W-1:0] pulse_cnt;
        logic cnt_prev;
        logic [FCP_VAL_W-1:0] disp_val;
        fcp_range_e disp_rng;
        logic disp_ovl;
        logic run;
        logic freeze;
        logic ack;
        logic [31:0] rdata;
        logic [FCP_VAL_W-1:0] o_val;
        logic o_ovl;
        logic [2:0] o_pts;
        logic o_hi;
        logic o_lo;
        logic o_buz;
        logic o_az;
        logic [11:0] o_integ;
        fcp_mode_e mode;
    } fcp_top_s;
    fcp_top_s st_reg;
    fcp_top_s st_next;

    logic [5:0] pins_s;
    logic meas_s;
    logic cnt_s;
    logic probe_s;
    logic pt0_s;
    logic pt1_s;
    logic peak_s;

    fcp_sync #(
        .WIDTH(6)
    ) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .PIN_IN({PEAK_READING_HOLD, POINT1_OR_HIGH_PROBE_INPUT,
                 POINT0_OR_LOW_PROBE_INPUT, PROBE_SELECT,
                 RANGE_OR_COUNT_INPUT, MEASUREMENT_SELECT}),
        .PIN_OUT(pins_s)
    );
    assign {peak_s, pt1_s, pt0_s, probe_s, cnt_s, meas_s} = pins_s;

    // ------------------------------------------------------------------
    // decade scaling of the raw count
    // ------------------------------------------------------------------
    function automatic logic [FCP_CNT_W-1:0] scale(input logic [FCP_CNT_W-1:0] c,
                                                    input fcp_range_e r);
        unique case (r)
            FCP_RNG_KHZ4: scale = c;
            FCP_RNG_KHZ40: scale = c / 23'd10;
            FCP_RNG_KHZ400: scale = c / 23'd100;
            FCP_RNG_MHZ4: scale = c / 23'd1000;
        endcase
    endfunction

    logic osc_tick;
    logic gate_end;
    fcp_range_e auto_rng;
    fcp_range_e use_rng;
    logic [FCP_CNT_W-1:0] scaled;
    logic new_ovl;
    logic take;
    logic acc;

    always_comb
    begin
        st_next = st_reg;
        osc_tick = (st_reg.osc_cnt == FCP_DIV_W'(OSC_DIV - 1));
        gate_end = osc_tick && (st_reg.gate_cnt == FCP_DIV_W'(GATE_PERIODS - 1));
        acc = (AVS_READ || AVS_WRITE) && !st_reg.ack;

        // oscillator enable and gate time base
        st_next.osc_cnt = osc_tick ? '0 : FCP_DIV_W'(st_reg.osc_cnt + 1'b1);
        if (osc_tick)
            st_next.gate_cnt = gate_end ? '0 : FCP_DIV_W'(st_reg.gate_cnt + 1'b1);

        // range choice: the full four decades unless peak hold pins it
        if (st_reg.pulse_cnt < FCP_LIM_R0)
            auto_rng = FCP_RNG_KHZ4;
        else if (st_reg.pulse_cnt < FCP_LIM_R1)
            auto_rng = FCP_RNG_KHZ40;
        else if (st_reg.pulse_cnt < FCP_LIM_R2)
            auto_rng = FCP_RNG_KHZ400;
        else
            auto_rng = FCP_RNG_MHZ4;
        use_rng = peak_s ? st_reg.disp_rng : auto_rng;
        scaled = scale(st_reg.pulse_cnt, use_rng);
        new_ovl = (scaled > FCP_CNT_W'(FCP_FULL_SCALE)) || (st_reg.pulse_cnt >= FCP_LIM_R3);
        // peak hold only lets a higher reading (or an overload) through
        take = !st_reg.freeze && (!peak_s || new_ovl ||
               (!st_reg.disp_ovl && scaled[FCP_VAL_W-1:0] > st_reg.disp_val));

        // pulse counting goes on whenever counter is selected and run is set, probe or not
        st_next.cnt_prev = cnt_s;
        if (gate_end)
        begin
            if (take && meas_s)
            begin
                st_next.disp_val = new_ovl ? FCP_FULL_SCALE : scaled[FCP_VAL_W-1:0];
                st_next.disp_rng = use_rng;
                st_next.disp_ovl = new_ovl;
            end
            st_next.pulse_cnt = '0;
        end
        else if (meas_s && st_reg.run && cnt_s && !st_reg.cnt_prev
                 && st_reg.pulse_cnt < FCP_LIM_R3)
            st_next.pulse_cnt = FCP_CNT_W'(st_reg.pulse_cnt + 1'b1);

        // mode decode
        if (probe_s)
            st_next.mode = FCP_MODE_PROBE;
        else if (meas_s)
            st_next.mode = FCP_MODE_COUNT;
        else
            st_next.mode = FCP_MODE_CONV;

        // display and annunciators, all registered
        st_next.o_hi = probe_s && pt1_s;
        st_next.o_lo = probe_s && pt0_s;
        st_next.o_buz = probe_s && pt0_s;
        st_next.o_az = probe_s && !meas_s;
        st_next.o_integ = (!probe_s && !meas_s && cnt_s) ? FCP_INTEG_SHORT
                                                         : FCP_INTEG_NORMAL;
        st_next.o_pts = 3'b000;
        if (meas_s)
        begin
            unique case (st_reg.disp_rng)
                FCP_RNG_KHZ4: st_next.o_pts = 3'b100;
                FCP_RNG_KHZ40: st_next.o_pts = 3'b010;
                FCP_RNG_KHZ400: st_next.o_pts = 3'b001;
                FCP_RNG_MHZ4: st_next.o_pts = 3'b000;
            endcase
        end
        else if (!probe_s)
        begin
            unique case ({pt1_s, pt0_s})
                2'b00: st_next.o_pts = 3'b000;
                2'b01: st_next.o_pts = 3'b001;
                2'b10: st_next.o_pts = 3'b010;
                2'b11: st_next.o_pts = 3'b100;
            endcase
        end
        if (probe_s)
        begin
            st_next.o_val = '0;
            st_next.o_ovl = 1'b1;
        end
        else if (meas_s)
        begin
            // held reading is shown directly, so leaving probe is immediate
            st_next.o_val = st_reg.disp_val;
            st_next.o_ovl = st_reg.disp_ovl;
        end
        else
        begin
            st_next.o_val = '0;
            st_next.o_ovl = 1'b0;
        end

        // register slave: one wait cycle, then the answer; a write lands only
        // at the edge where waitrequest is low, so an aborted request is harmless
        st_next.ack = acc;
        if (st_reg.ack && AVS_WRITE && AVS_ADDRESS == FCP_ADDR_CTRL)
        begin
            st_next.run = AVS_WRITEDATA[FCP_CTRL_RUN_BIT];
            st_next.freeze = AVS_WRITEDATA[FCP_CTRL_FREEZE_BIT];
        end
        if (acc && AVS_READ)
        begin
            unique case (AVS_ADDRESS)
                FCP_ADDR_CTRL: st_next.rdata = {30'h00000000, st_reg.freeze, st_reg.run};
                FCP_ADDR_STATUS: st_next.rdata = {23'h000000, peak_s, st_reg.disp_rng,
                                  st_reg.o_ovl, st_reg.o_buz, st_reg.o_lo, st_reg.o_hi,
                                  st_reg.mode};
                FCP_ADDR_READING: st_next.rdata = {17'h00000, st_reg.disp_ovl,
                                  st_reg.disp_rng, st_reg.disp_val};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st_reg <= '0;
            st_reg.run <= FCP_CTRL_RUN_RST;
            st_reg.freeze <= FCP_CTRL_FREEZE_RST;
            st_reg.o_integ <= FCP_INTEG_NORMAL;
        end
        else
            st_reg <= st_next;
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !st_reg.ack;
    assign AVS_READDATA = st_reg.rdata;
    assign DISPLAY_VALUE = st_reg.o_val;
    assign OVERLOAD_TEXT = st_reg.o_ovl;
    assign {THIRD_DECIMAL_POINT, SECOND_DECIMAL_POINT, FIRST_DECIMAL_POINT} = st_reg.o_pts;
    assign LAMP_HIGH = st_reg.o_hi;
    assign LAMP_LOW = st_reg.o_lo;
    assign BUZZER_ON = st_reg.o_buz;
    assign CONV_HOLD_AUTOZERO = st_reg.o_az;
    assign CONV_INTEG_COUNTS = st_reg.o_integ;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    gate_length_a: assert property (gate_end |=> st_reg.gate_cnt == '0 && st_reg.osc_cnt == '0)
        else $error("gate time base did not restart");
    gate_clear_a: assert property (gate_end |=> st_reg.pulse_cnt == '0)
        else $error("pulse counter not cleared after gate");
    probe_force_a: assert property (probe_s |=> st_reg.mode == FCP_MODE_PROBE && OVERLOAD_TEXT)
        else $error("probe select did not force probe mode");
    probe_lamps_a: assert property (probe_s && pt1_s |=> LAMP_HIGH)
        else $error("high lamp not lit");
    buzzer_low_a: assert property (LAMP_LOW |-> BUZZER_ON)
        else $error("buzzer off while low lamp lit");
    conv_probe_a: assert property (probe_s && !meas_s |=> CONV_HOLD_AUTOZERO
        && st_reg.o_pts == 3'b000) else $error("probe over converter wrong");
    count_probe_a: assert property (probe_s && meas_s && st_reg.run && cnt_s && !st_reg.cnt_prev
        && !gate_end && st_reg.pulse_cnt < FCP_LIM_R3 |=> st_reg.pulse_cnt == $past(st_reg.pulse_cnt)
        + 1'b1) else $error("counting stopped under probe");
    leave_probe_a: assert property ($fell(probe_s) && meas_s ##1 meas_s |=>
        DISPLAY_VALUE == $past(st_reg.disp_val)) else $error("reading not shown at once");
    integ_short_a: assert property (!probe_s && !meas_s && cnt_s |=>
        CONV_INTEG_COUNTS == FCP_INTEG_SHORT) else $error("short integrate not chosen");
    peak_range_a: assert property (gate_end && peak_s && meas_s |=>
        st_reg.disp_rng == $past(st_reg.disp_rng)) else $error("range moved under peak hold");
    point_map_a: assert property (!probe_s && meas_s && st_reg.disp_rng == FCP_RNG_KHZ4 |=>
        THIRD_DECIMAL_POINT) else $error("third point not lit in lowest range");
    bus_wait_a: assert property (AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("slave waited more than one cycle");

    gate_seen_c: cover property (gate_end && meas_s);
    probe_count_c: cover property (probe_s && meas_s ##1 !probe_s);
    top_range_c: cover property (gate_end && auto_rng == FCP_RNG_MHZ4);
endmodule // fcp_top

//--- fcp_pin_model.sv
// fcp_pin_model.sv: model of the controller that sets the mode pins and
// feeds a square wave to the range/count input.
// assumes the bench changes its commands just after a rising edge of CLK.
`timescale 1ns/1ps
module fcp_pin_model (
    // clock
    input wire logic CLK,
    // commands from the bench
    input wire logic cmd_sel,
    input wire logic cmd_probe,
    input wire logic cmd_p0,
    input wire logic cmd_p1,
    input wire logic cmd_peak,
    input wire logic cmd_lvl,
    input wire logic [3:0] cmd_period,
    // mode pins
    output logic MEASUREMENT_SELECT = 1'b0,
    output logic RANGE_OR_COUNT_INPUT = 1'b0,
    output logic PROBE_SELECT = 1'b0,
    output logic POINT0_OR_LOW_PROBE_INPUT = 1'b0,
    output logic POINT1_OR_HIGH_PROBE_INPUT = 1'b0,
    output logic PEAK_READING_HOLD = 1'b0
);
    logic [3:0] phase_reg = 4'h0;
    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    // period 0 holds the range input at a level; otherwise high for period/2 (rounded down) of each period,
    // so even periods of 4 or more give the synchroniser two cycles each
    always @(posedge CLK)
    begin
        if (cmd_period == 4'h0 || phase_reg >= cmd_period - 4'h1)
            phase_reg <= 4'h0;
        else
            phase_reg <= phase_reg + 4'h1;
        if (cmd_period == 4'h0)
            RANGE_OR_COUNT_INPUT <= cmd_lvl;
        else
            RANGE_OR_COUNT_INPUT <= (phase_reg < (cmd_period >> 1));
        MEASUREMENT_SELECT <= cmd_sel;
        PROBE_SELECT <= cmd_probe;
        POINT0_OR_LOW_PROBE_INPUT <= cmd_p0;
        POINT1_OR_HIGH_PROBE_INPUT <= cmd_p1;
        PEAK_READING_HOLD <= cmd_peak;
    end
endmodule // fcp_pin_model

//--- tb_fcp_top.sv
// tb_fcp_top.sv: self-checking bench for the counter/probe mode block.
// assumes a shortened gate (OSC_DIV 4, 4000 periods) so each run of the
// counter needs two gates of 16000 cycles to settle.
`timescale 1ns/1ps
module tb_fcp_top;
    import fcp_pkg::*;
    localparam int OSC_DIV_TB = 4;
    localparam int GATE_TB = 4000;
    localparam int GATE_CYC = OSC_DIV_TB * GATE_TB;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sel = 1'b0, probe = 1'b0, p0 = 1'b0, p1 = 1'b0, peak = 1'b0, lvl = 1'b0;
    logic [3:0] period = 4'h0;
    logic pin_sel, pin_rng, pin_probe, pin_p0, pin_p1, pin_peak;
    logic [11:0] disp;
    logic [11:0] integ;
    logic ovl, dp3, dp2, dp1, lamp_hi, lamp_lo, buzz, hold_az;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] rd;

    always #2 clk = ~clk;

    fcp_pin_model u_pins (.CLK(clk), .cmd_sel(sel), .cmd_probe(probe), .cmd_p0(p0),
        .cmd_p1(p1), .cmd_peak(peak), .cmd_lvl(lvl), .cmd_period(period),
        .MEASUREMENT_SELECT(pin_sel), .RANGE_OR_COUNT_INPUT(pin_rng),
        .PROBE_SELECT(pin_probe), .POINT0_OR_LOW_PROBE_INPUT(pin_p0),
        .POINT1_OR_HIGH_PROBE_INPUT(pin_p1), .PEAK_READING_HOLD(pin_peak));

    fcp_top #(.GATE_PERIODS(GATE_TB), .OSC_DIV(OSC_DIV_TB)) u_dut (.CLK(clk), .RST_N(rst_n),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .MEASUREMENT_SELECT(pin_sel),
        .RANGE_OR_COUNT_INPUT(pin_rng), .PROBE_SELECT(pin_probe),
        .POINT0_OR_LOW_PROBE_INPUT(pin_p0), .POINT1_OR_HIGH_PROBE_INPUT(pin_p1),
        .PEAK_READING_HOLD(pin_peak), .DISPLAY_VALUE(disp), .OVERLOAD_TEXT(ovl),
        .THIRD_DECIMAL_POINT(dp3), .SECOND_DECIMAL_POINT(dp2), .FIRST_DECIMAL_POINT(dp1),
        .LAMP_HIGH(lamp_hi), .LAMP_LOW(lamp_lo), .BUZZER_ON(buzz),
        .CONV_HOLD_AUTOZERO(hold_az), .CONV_INTEG_COUNTS(integ));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one avalon access; entered just after a rising edge, leaves one idle cycle
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20)
        begin
            mismatches++;
            report_and_stop();
        end
        @(posedge clk);
    endtask

    task automatic check_pts(input logic [2:0] exp);
        check({29'h0, dp3, dp2, dp1}, {29'h0, exp});
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_and_regs;
        check({20'h0, integ}, {20'h0, FCP_INTEG_NORMAL});
        check({20'h0, disp}, 32'h0);
        check({29'h0, ovl, lamp_lo, buzz}, 32'h0);
        bus(1'b0, FCP_ADDR_CTRL, 32'h0);
        check(rd, 32'h1);
        bus(1'b0, 4'hC, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, FCP_ADDR_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, FCP_ADDR_STATUS, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, FCP_ADDR_CTRL, 32'h3);
        bus(1'b0, FCP_ADDR_CTRL, 32'h0);
        check(rd, 32'h3);
        bus(1'b1, FCP_ADDR_CTRL, 32'h1);
    endtask

    task automatic t_converter;
        logic [2:0] exp_pts [4];
        exp_pts = '{3'b000, 3'b001, 3'b010, 3'b100};
        for (int i = 0; i < 4; i++)
        begin
            p0 <= i[0];
            p1 <= i[1];
            wait_cyc(6);
            check_pts(exp_pts[i]);
            check({31'h0, lamp_hi | lamp_lo}, 32'h0);
        end
        lvl <= 1'b1;
        wait_cyc(6);
        check({20'h0, integ}, {20'h0, FCP_INTEG_SHORT});
    endtask

    task automatic t_probe_conv;
        probe <= 1'b1;
        wait_cyc(6);
        check({28'h0, hold_az, ovl, lamp_hi, lamp_lo}, 32'hF);
        check_pts(3'b000);
        check({31'h0, buzz}, 32'h1);
        bus(1'b0, FCP_ADDR_STATUS, 32'h0);
        check(rd & 32'h3, 32'h2);
        probe <= 1'b0;
        lvl <= 1'b0;
        wait_cyc(6);
        check({30'h0, hold_az, ovl}, 32'h0);
        check_pts(3'b100);
        check({20'h0, integ}, {20'h0, FCP_INTEG_NORMAL});
        p0 <= 1'b0;
        p1 <= 1'b0;
    endtask

    // settles over two whole gates after the pulse rate changes
    task automatic t_count(input logic [3:0] per, input int exp_val, input logic [2:0] pts);
        sel <= 1'b1;
        period <= per;
        wait_cyc(2 * GATE_CYC + 10);
        check({20'h0, disp}, exp_val);
        check_pts(pts);
        check({31'h0, ovl}, 32'h0);
    endtask

    task automatic t_probe_count;
        probe <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            p0 <= i[0];
            p1 <= i[1];
            wait_cyc(6);
            check({30'h0, lamp_hi, lamp_lo}, {30'h0, i[1], i[0]});
            check({31'h0, buzz}, {31'h0, i[0]});
            check({30'h0, ovl, dp2}, 32'h3);
        end
        probe <= 1'b0;
        p0 <= 1'b0;
        p1 <= 1'b0;
        wait_cyc(5);
        check({20'h0, disp}, GATE_CYC / 40);
        check({31'h0, ovl}, 32'h0);
    endtask

    task automatic t_peak;
        peak <= 1'b1;
        period <= 4'h8;
        wait_cyc(2 * GATE_CYC + 10);
        check({20'h0, disp}, GATE_CYC / 40);
        check_pts(3'b010);
        bus(1'b0, FCP_ADDR_STATUS, 32'h0);
        check(rd & 32'h1C3, 32'h141);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        wait_cyc(8);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_and_regs();
        t_converter();
        t_probe_conv();
        t_count(4'h8, GATE_CYC / 8, 3'b100);
        t_count(4'h4, GATE_CYC / 40, 3'b010);
        bus(1'b0, FCP_ADDR_READING, 32'h0);
        check(rd & 32'h7FFF, 32'h1000 | (GATE_CYC / 40));
        bus(1'b0, FCP_ADDR_STATUS, 32'h0);
        check(rd & 32'h1FF, 32'h41);
        t_probe_count();
        t_peak();
        report_and_stop();
    end
endmodule // tb_fcp_top
